/* File: wrsp_apb_master.sv */
/*
 * wrsp_apb_master: APB requester standing in for the host processor.
 * Assumes one clock; completer may add wait states.
 */
`timescale 1ns/1ps
`default_nettype none

module wrsp_apb_master
    import wrsp_pkg::*;
(
    input  wire logic              i_clk,
    input  wire logic              i_pready,
    input  wire logic              i_pslverr,
    input  wire logic [DATA_W-1:0] i_prdata,
    output logic                   o_psel,
    output logic                   o_penable,
    output logic                   o_pwrite,
    output logic [ADDR_W-1:0]      o_paddr,
    output logic [DATA_W-1:0]      o_pwdata,
    output logic [PROT_W-1:0]      o_pprot
);
    initial {o_psel, o_penable, o_pwrite, o_paddr, o_pwdata, o_pprot} = '0;

    // ==========================================================
    // one transfer after idle cycles, held until ready or 16 access cycles
    task automatic xfer(input logic wr, input logic [7:0] a, input logic [31:0] d, input logic [2:0] p,
                        input int idle, output logic [31:0] rd, output logic err);
        int n;
        n = 0;
        repeat (idle + 1) @(posedge i_clk);
        {o_psel, o_pwrite, o_paddr, o_pwdata} <= {1'b1, wr, a, d};
        o_pprot <= p;
        @(posedge i_clk);
        o_penable <= 1'b1;
        do
        begin
            @(posedge i_clk);
            n++;
        end
        while (i_pready !== 1'b1 && n < 16);
        rd = i_prdata;
        err = (i_pready === 1'b1) ? i_pslverr : 1'bx;
        {o_psel, o_penable, o_paddr, o_pwdata, o_pprot} <= {2'b00, ~a, ~d, ~p};
    endtask
endmodule

`default_nettype wire

/* File: wrsp_pkg.sv */
/*
 * wrsp_pkg: offsets, field positions, reset values and encodings
 * for the watchdog restart, status and parameter register bank.
 * Assumes a 32-bit APB data bus and word-aligned register offsets.
 */
`default_nettype none

package wrsp_pkg;

    // ==========================================================
    // bus geometry
    localparam int unsigned ADDR_W       = 8;
    localparam int unsigned DATA_W       = 32;
    localparam int unsigned PROT_W       = 3;

    // ==========================================================
    // register offsets
    localparam logic [7:0] OFS_RESTART   = 8'h0c;
    localparam logic [7:0] OFS_STATUS    = 8'h10;
    localparam logic [7:0] OFS_INT_ACK   = 8'h14;
    localparam logic [7:0] OFS_PROT      = 8'h1c;
    localparam logic [7:0] OFS_USER_MAX  = 8'he4;
    localparam logic [7:0] OFS_INIT_MAX  = 8'he8;
    localparam logic [7:0] OFS_TOP_RST   = 8'hec;
    localparam logic [7:0] OFS_CNT_RST   = 8'hf0;
    localparam logic [7:0] OFS_SUMMARY   = 8'hf4;
    localparam logic [7:0] OFS_VERSION   = 8'hf8;
    localparam logic [7:0] OFS_TYPE      = 8'hfc;

    // ==========================================================
    // field values
    localparam logic [7:0] RESTART_KEY   = 8'h76;
    localparam logic [4:0] CNT_W_BIAS    = 5'h10;
    localparam logic [1:0] BUS_W_8       = 2'h0;
    localparam logic [1:0] BUS_W_16      = 2'h1;
    localparam logic [1:0] BUS_W_32      = 2'h2;

    // ==========================================================
    // summary register field positions
    localparam int unsigned SUM_CNT_W_LSB = 24;
    localparam int unsigned SUM_INIT_LSB  = 20;
    localparam int unsigned SUM_TOP_LSB   = 16;
    localparam int unsigned SUM_RPL_LSB   = 10;
    localparam int unsigned SUM_BUS_LSB   = 8;
    localparam int unsigned SUM_PAUSE     = 7;
    localparam int unsigned SUM_FIX_TOP   = 6;
    localparam int unsigned SUM_HC_TOP    = 5;
    localparam int unsigned SUM_HC_RPL    = 4;
    localparam int unsigned SUM_HC_RESP   = 3;
    localparam int unsigned SUM_DUAL_TOP  = 2;
    localparam int unsigned SUM_DFLT_RESP = 1;
    localparam int unsigned SUM_ALWAYS_EN = 0;

    // ==========================================================
    // reset values
    localparam logic [DATA_W-1:0] RST_DATA = 32'h0000_0000;

    // ==========================================================
    // timeout response state
    typedef enum logic [1:0]
    {
        WRSP_ARMED  = 2'b01,
        WRSP_WARNED = 2'b10
    } wrsp_resp_e;

endpackage

`default_nettype wire

/* File: wrsp_regs.sv */
/*
 * wrsp_regs: upper register bank of a watchdog timer behind an APB slave:
 * keyed restart, interrupt status, read-to-clear acknowledge, protection
 * level, constant parameter, version and type registers, plus the sticky
 * enable and the interrupt-then-reset response tracking.
 * Assumes the counter core sits outside, consumes o_restart, o_intr_clear,
 * o_wdt_enabled, o_counter_freeze, and pulses i_timeout at zero count.
 */
`timescale 1ns/1ps
`default_nettype none

module wrsp_regs
    import wrsp_pkg::*;
#(
    parameter int unsigned    SLAVE_IF_TYPE      = 2,
    parameter bit             ERR_RESP_EN        = 1'b1,
    parameter bit             PROT_HARDWIRED     = 1'b0,
    parameter logic [2:0]     PROT_LEVEL_RST     = 3'h0,
    parameter int unsigned    COUNTER_WIDTH      = 32,
    parameter logic [31:0]    USER_TOP_MAX       = 32'h0000_0000,
    parameter logic [31:0]    USER_TOP_INIT_MAX  = 32'h0000_0000,
    parameter logic [31:0]    TOP_RST            = 32'h0000_0000,
    parameter logic [31:0]    CNT_RST            = 32'hffff_ffff,
    parameter logic [3:0]     DFLT_INIT_SEL      = 4'h0,
    parameter logic [3:0]     DFLT_TIMEOUT_SEL   = 4'h0,
    parameter logic [2:0]     DFLT_PULSE_LEN     = 3'h0,
    parameter bit             PAUSE_PRESENT      = 1'b0,
    parameter bit             USE_FIX_TOP        = 1'b1,
    parameter bit             TIMEOUT_HARDWIRED  = 1'b0,
    parameter bit             PULSE_HARDWIRED    = 1'b0,
    parameter bit             RESPONSE_HARDWIRED = 1'b0,
    parameter bit             DUAL_TOP           = 1'b0,
    parameter bit             DFLT_RESPONSE_SEL  = 1'b0,
    parameter bit             ALWAYS_EN          = 1'b0,
    // arbitrary example version string "100*"
    parameter logic [31:0]    VERSION_ID         = 32'h3130_302a,
    // arbitrary neutral type code
    parameter logic [31:0]    TYPE_CODE          = 32'h5854_0001
)
(
    input  wire logic              i_clk,
    input  wire logic              i_rst_b,
    input  wire logic              i_psel,
    input  wire logic              i_penable,
    input  wire logic              i_pwrite,
    input  wire logic [ADDR_W-1:0] i_paddr,
    input  wire logic [DATA_W-1:0] i_pwdata,
    input  wire logic [PROT_W-1:0] i_pprot,
    input  wire logic              i_enable_set,
    input  wire logic              i_response_select,
    input  wire logic              i_timeout,
    input  wire logic              i_pause,
    output logic [DATA_W-1:0]      o_prdata,
    output logic                   o_pready,
    output logic                   o_pslverr,
    output logic                   o_restart,
    output logic                   o_intr_clear,
    output logic                   o_intr,
    output logic                   o_sys_rst,
    output logic                   o_wdt_enabled,
    output logic                   o_counter_freeze
);

    // ==========================================================
    // configuration constants
    localparam bit PROT_VISIBLE = (SLAVE_IF_TYPE > 1) && ERR_RESP_EN;
    localparam bit PROT_EXISTS  = PROT_VISIBLE && !PROT_HARDWIRED;
    localparam logic [4:0] CNT_W_FIELD = 5'(COUNTER_WIDTH) - CNT_W_BIAS;
    localparam logic [1:0] BUS_W_CODE  = (DATA_W == 8)  ? BUS_W_8 :
                                         (DATA_W == 16) ? BUS_W_16 : BUS_W_32;

    // ==========================================================
    // registers
    logic [2:0]        prot_level_reg;
    logic [DATA_W-1:0] prdata_reg;
    logic [DATA_W-1:0] prdata_next;
    logic              pready_reg;
    logic              pslverr_reg;
    logic              pslverr_next;
    logic              intr_reg;
    logic              intr_next;
    logic              restart_reg;
    logic              intr_clear_reg;
    logic              sys_rst_reg;
    logic              enabled_reg;
    logic              freeze_reg;
    wrsp_resp_e        resp_reg;
    wrsp_resp_e        resp_next;

    logic [DATA_W-1:0] summary;
    logic              setup_phase;
    logic              access_done;
    logic              prot_ok;
    logic              is_protected;
    logic              granted;
    logic              restart_hit;
    logic              ack_hit;
    logic              prot_wr;
    logic              timeout_live;

    // ==========================================================
    // apb decode
    assign setup_phase  = i_psel && !i_penable;
    assign access_done  = i_psel && i_penable && pready_reg;
    // every set level bit must also be set in pprot
    assign prot_ok      = ((i_pprot & prot_level_reg) == prot_level_reg);
    assign is_protected = (i_paddr == OFS_RESTART) || (i_paddr == OFS_INT_ACK) ||
                          (i_paddr == OFS_PROT);
    assign granted      = !(PROT_VISIBLE && is_protected && !prot_ok);

    assign restart_hit  = access_done && i_pwrite && granted && (i_paddr == OFS_RESTART)
                          && (i_pwdata[7:0] == RESTART_KEY);
    assign ack_hit      = access_done && !i_pwrite && granted && (i_paddr == OFS_INT_ACK);
    assign prot_wr      = access_done && i_pwrite && granted && (i_paddr == OFS_PROT)
                          && PROT_EXISTS;

    // ==========================================================
    // configuration summary word
    always_comb
    begin
        summary = RST_DATA;
        summary[SUM_CNT_W_LSB +: 5] = CNT_W_FIELD;
        summary[SUM_INIT_LSB +: 4]  = DFLT_INIT_SEL;
        summary[SUM_TOP_LSB +: 4]   = DFLT_TIMEOUT_SEL;
        summary[SUM_RPL_LSB +: 3]   = DFLT_PULSE_LEN;
        summary[SUM_BUS_LSB +: 2]   = BUS_W_CODE;
        summary[SUM_PAUSE]          = PAUSE_PRESENT;
        summary[SUM_FIX_TOP]        = USE_FIX_TOP;
        summary[SUM_HC_TOP]         = TIMEOUT_HARDWIRED;
        summary[SUM_HC_RPL]         = PULSE_HARDWIRED;
        summary[SUM_HC_RESP]        = RESPONSE_HARDWIRED;
        summary[SUM_DUAL_TOP]       = DUAL_TOP;
        summary[SUM_DFLT_RESP]      = DFLT_RESPONSE_SEL;
        summary[SUM_ALWAYS_EN]      = ALWAYS_EN;
    end

    // ==========================================================
    // read mux, evaluated in the setup phase
    always_comb
    begin
        prdata_next = RST_DATA;
        if (!i_pwrite && granted)
        begin
            unique case (i_paddr)
                OFS_STATUS:   prdata_next[0] = intr_reg;
                OFS_PROT:     prdata_next[2:0] = PROT_VISIBLE ? prot_level_reg : 3'h0;
                OFS_USER_MAX: prdata_next = USER_TOP_MAX;
                OFS_INIT_MAX: prdata_next = USER_TOP_INIT_MAX;
                OFS_TOP_RST:  prdata_next = TOP_RST;
                OFS_CNT_RST:  prdata_next = CNT_RST;
                OFS_SUMMARY:  prdata_next = summary;
                OFS_VERSION:  prdata_next = VERSION_ID;
                OFS_TYPE:     prdata_next = TYPE_CODE;
                // restart, acknowledge and unmapped read zero
                default:      prdata_next = RST_DATA;
            endcase
        end
        pslverr_next = PROT_VISIBLE && is_protected && !prot_ok;
    end

    // ==========================================================
    // apb response: one wait-free access phase
    always_ff @(posedge i_clk or negedge i_rst_b)
    begin
        if (!i_rst_b)
        begin
            pready_reg  <= 1'b0;
            pslverr_reg <= 1'b0;
            prdata_reg  <= RST_DATA;
        end
        else if (setup_phase)
        begin
            pready_reg  <= 1'b1;
            pslverr_reg <= pslverr_next;
            prdata_reg  <= prdata_next;
        end
        else
        begin
            pready_reg  <= 1'b0;
            pslverr_reg <= 1'b0;
            prdata_reg  <= RST_DATA;
        end
    end

    // ==========================================================
    // protection level
    always_ff @(posedge i_clk or negedge i_rst_b)
    begin
        if (!i_rst_b)
        begin
            prot_level_reg <= PROT_LEVEL_RST;
        end
        else if (prot_wr)
        begin
            prot_level_reg <= i_pwdata[2:0];
        end
    end

    // ==========================================================
    // restart strobe to the counter core
    always_ff @(posedge i_clk or negedge i_rst_b)
    begin
        if (!i_rst_b)
        begin
            restart_reg <= 1'b0;
        end
        else
        begin
            restart_reg <= restart_hit;
        end
    end

    // ==========================================================
    // acknowledge strobe, counter left running
    always_ff @(posedge i_clk or negedge i_rst_b)
    begin
        if (!i_rst_b)
        begin
            intr_clear_reg <= 1'b0;
        end
        else
        begin
            intr_clear_reg <= ack_hit;
        end
    end

    // ==========================================================
    // sticky enable, cleared only by reset
    always_ff @(posedge i_clk or negedge i_rst_b)
    begin
        if (!i_rst_b)
        begin
            enabled_reg <= ALWAYS_EN;
        end
        else
        begin
            enabled_reg <= enabled_reg || i_enable_set;
        end
    end

    // ==========================================================
    // pause freeze
    always_ff @(posedge i_clk or negedge i_rst_b)
    begin
        if (!i_rst_b)
        begin
            freeze_reg <= 1'b0;
        end
        else
        begin
            freeze_reg <= PAUSE_PRESENT && i_pause;
        end
    end

    // ==========================================================
    // timeouts that count: enabled and not paused
    assign timeout_live = i_timeout && enabled_reg && !freeze_reg;

    // ==========================================================
    // timeout response and interrupt flag
    always_comb
    begin
        resp_next = resp_reg;
        intr_next = intr_reg;
        if (restart_hit)
        begin
            resp_next = WRSP_ARMED;
            intr_next = 1'b0;
        end
        else if (ack_hit)
        begin
            // acknowledge leaves the tracker as it is
            intr_next = 1'b0;
        end
        // a same-cycle timeout wins over either clear
        if (timeout_live)
        begin
            unique case (resp_reg)
                WRSP_ARMED:
                begin
                    if (i_response_select)
                    begin
                        resp_next = WRSP_WARNED;
                        intr_next = 1'b1;
                    end
                end
                WRSP_WARNED: resp_next = WRSP_WARNED;
            endcase
        end
    end

    always_ff @(posedge i_clk or negedge i_rst_b)
    begin
        if (!i_rst_b)
        begin
            resp_reg <= WRSP_ARMED;
        end
        else
        begin
            resp_reg <= resp_next;
        end
    end

    // ==========================================================
    // pending interrupt flag
    always_ff @(posedge i_clk or negedge i_rst_b)
    begin
        if (!i_rst_b)
        begin
            intr_reg <= 1'b0;
        end
        else
        begin
            intr_reg <= intr_next;
        end
    end

    // ==========================================================
    // system reset request
    always_ff @(posedge i_clk or negedge i_rst_b)
    begin
        if (!i_rst_b)
        begin
            sys_rst_reg <= 1'b0;
        end
        else
        begin
            // second timeout resets even after the interrupt was acknowledged
            sys_rst_reg <= timeout_live && ((resp_reg == WRSP_WARNED) || !i_response_select);
        end
    end

    // ==========================================================
    // outputs
    assign o_prdata         = prdata_reg;
    assign o_pready         = pready_reg;
    assign o_pslverr        = pslverr_reg;
    assign o_restart        = restart_reg;
    assign o_intr_clear     = intr_clear_reg;
    assign o_intr           = intr_reg;
    assign o_sys_rst        = sys_rst_reg;
    assign o_wdt_enabled    = enabled_reg;
    assign o_counter_freeze = freeze_reg;

endmodule

`default_nettype wire

/* File: wrsp_regs_properties.sv */
/*
 * wrsp_regs_properties: port-level timing checks for wrsp_regs.
 * Assumes a bind onto wrsp_regs, one clock, async low reset.
 */
`timescale 1ns/1ps
`default_nettype none

module wrsp_regs_properties
    import wrsp_pkg::*;
#(
    parameter int unsigned COUNTER_WIDTH = 32
)
(
    input wire logic              i_clk,
    input wire logic              i_rst_b,
    input wire logic              i_psel,
    input wire logic              i_penable,
    input wire logic              i_pwrite,
    input wire logic [ADDR_W-1:0] i_paddr,
    input wire logic [DATA_W-1:0] i_pwdata,
    input wire logic              i_timeout,
    input wire logic [DATA_W-1:0] o_prdata,
    input wire logic              o_pready,
    input wire logic              o_pslverr,
    input wire logic              o_restart,
    input wire logic              o_intr_clear,
    input wire logic              o_intr,
    input wire logic              o_sys_rst,
    input wire logic              o_wdt_enabled,
    input wire logic              o_counter_freeze
);
    localparam logic [4:0] CW_CODE = 5'(COUNTER_WIDTH - 16);
    default clocking cb @(posedge i_clk); endclocking
    default disable iff (!i_rst_b);

    // ==========================================================
    // access phase of a completed read
    sequence s_rd(logic [7:0] a);
        o_pready && i_psel && i_penable && !i_pwrite && i_paddr == a;
    endsequence
    sequence s_quiet;
        !o_restart && !o_intr_clear;
    endsequence

    AST_RESTART_CAUSE:
        assert property (o_restart |-> $past(o_pready && i_pwrite && !o_pslverr && i_paddr == OFS_RESTART
            && i_pwdata[7:0] == RESTART_KEY)) else $error("restart without key write");
    AST_RESTART_CLEARS:
        assert property (o_restart && !$past(i_timeout) |-> !o_intr) else $error("restart left intr");
    AST_STATUS_READ:
        assert property (s_rd(OFS_STATUS) |-> o_prdata == {31'h0, $past(o_intr)}) else $error("bad status");
    AST_ACK_CAUSE:
        assert property (o_intr_clear |-> !o_restart && $past(o_pready && !i_pwrite && !o_pslverr
            && i_paddr == OFS_INT_ACK)) else $error("bad acknowledge pulse");
    AST_ACK_UPPER:
        assert property (s_rd(OFS_INT_ACK) |-> o_prdata[31:1] == 31'h0) else $error("ack upper bits");
    AST_DENY_QUIET:
        assert property (o_pslverr |-> o_pready && o_prdata == 32'h0 ##1 s_quiet) else $error("denial effect");
    AST_SUMMARY:
        assert property (s_rd(OFS_SUMMARY) |-> o_prdata[28:24] == CW_CODE && o_prdata[9:8] == BUS_W_32)
            else $error("bad summary");
    AST_FROZEN:
        assert property (i_timeout && o_counter_freeze && !o_intr |=> !o_intr && !o_sys_rst)
            else $error("timeout while frozen");
    AST_STICKY_EN:
        assert property (o_wdt_enabled |=> o_wdt_enabled) else $error("enable dropped");
    AST_SYSRST_PULSE:
        assert property (o_sys_rst |-> $past(i_timeout) ##1 !o_sys_rst) else $error("bad sys reset pulse");
endmodule

`default_nettype wire

/* File: wrsp_regs_tb.sv */
/*
 * wrsp_regs_tb: self-checking bench for wrsp_regs against a reference model.
 * Assumes wrsp_apb_master as host; drives counter-side inputs itself.
 */
`timescale 1ns/1ps
`default_nettype none

module wrsp_regs_tb
    import wrsp_pkg::*;
;
    localparam logic [31:0] UMAX = 32'h0001_2345;
    localparam logic [31:0] IMAX = 32'h0000_8fff;
    localparam logic [31:0] VER  = 32'h3332_312a; // arbitrary
    localparam logic [31:0] TYP  = 32'h515a_0003; // arbitrary
    localparam int          CW   = 24;
    localparam logic [31:0] TOPR = 32'h0000_0035;
    localparam logic [31:0] CNTR = 32'h00ff_ffff;
    localparam logic [3:0]  ISEL = 4'h2;
    localparam logic [3:0]  TSEL = 4'h5;
    localparam logic [2:0]  RPL  = 3'h4;
    localparam bit          PAUS = 1'b1;
    // width code, init, top, pulse, bus, flags pause, hc top, hc resp, dual, int-then-reset
    localparam logic [31:0] SUM  = {3'h0, 5'(CW - 16), ISEL, TSEL, 3'h0, RPL, BUS_W_32, PAUS, 7'b010_1110};
    logic        i_clk = 1'b0, i_rst_b = 1'b0, i_enable_set = 1'b0, i_response_select = 1'b1;
    logic        i_timeout = 1'b0, i_pause = 1'b0, i_psel, i_penable, i_pwrite, o_pready, o_pslverr;
    logic        o_restart, o_intr_clear, o_intr, o_sys_rst, o_wdt_enabled, o_counter_freeze;
    logic [7:0]  i_paddr;
    logic [31:0] i_pwdata, o_prdata;
    logic [2:0]  i_pprot, m_lvl;
    int          miscompares = 0, n_tests = 0, n_rst = 0, n_clr = 0, n_sys = 0;
    int          e_rst = 0, e_clr = 0, e_sys = 0, m_intr, m_warn, m_en;
    integer      seed = 32;
    logic [7:0]  tbl [12] = '{OFS_RESTART, OFS_STATUS, OFS_INT_ACK, OFS_PROT, OFS_USER_MAX, OFS_INIT_MAX,
                              OFS_TOP_RST, OFS_CNT_RST, OFS_SUMMARY, OFS_VERSION, OFS_TYPE, 8'h20};

    always #50 i_clk = ~i_clk;
    always @(posedge i_clk)
    begin
        n_rst += o_restart;
        n_clr += o_intr_clear;
        n_sys += o_sys_rst;
    end

    wrsp_regs #(.COUNTER_WIDTH(CW), .USER_TOP_MAX(UMAX), .USER_TOP_INIT_MAX(IMAX), .TOP_RST(TOPR),
        .CNT_RST(CNTR), .DFLT_INIT_SEL(ISEL), .DFLT_TIMEOUT_SEL(TSEL), .DFLT_PULSE_LEN(RPL),
        .PAUSE_PRESENT(PAUS), .USE_FIX_TOP(1'b0), .TIMEOUT_HARDWIRED(1'b1), .RESPONSE_HARDWIRED(1'b1),
        .DUAL_TOP(1'b1), .DFLT_RESPONSE_SEL(1'b1), .VERSION_ID(VER), .TYPE_CODE(TYP)) dut_u (.*);
    wrsp_apb_master m_u (.i_clk(i_clk), .i_pready(o_pready), .i_pslverr(o_pslverr), .i_prdata(o_prdata),
        .o_psel(i_psel), .o_penable(i_penable), .o_pwrite(i_pwrite), .o_paddr(i_paddr),
        .o_pwdata(i_pwdata), .o_pprot(i_pprot));

    // ==========================================================
    // model and checks
    task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
        n_tests++;
        if (seen !== exp)
        begin
            miscompares++;
            $display("Error %s expected %h seen %h", what, exp, seen);
        end
    endtask
    function automatic logic [31:0] exp_rd(input logic [7:0] a);
        case (a)
            OFS_STATUS:   return {31'h0, m_intr[0]};
            OFS_PROT:     return {29'h0, m_lvl};
            OFS_USER_MAX: return UMAX;
            OFS_INIT_MAX: return IMAX;
            OFS_TOP_RST:  return TOPR;
            OFS_CNT_RST:  return CNTR;
            OFS_SUMMARY:  return SUM;
            OFS_VERSION:  return VER;
            OFS_TYPE:     return TYP;
            default:      return 32'h0;
        endcase
    endfunction
    task automatic settle;
        @(posedge i_clk);
        #1;
        chk("restarts", n_rst, e_rst);
        chk("acks", n_clr, e_clr);
        chk("sysrst", n_sys, e_sys);
        chk("intr", {31'h0, o_intr}, m_intr);
        chk("enabled", {31'h0, o_wdt_enabled}, m_en);
        chk("freeze", {31'h0, o_counter_freeze}, {31'h0, i_pause});
    endtask
    task automatic op(input logic wr, input logic [7:0] a, input logic [31:0] d, input logic [2:0] p);
        logic [31:0] rd;
        logic        err, eerr;
        eerr = (a == OFS_RESTART || a == OFS_INT_ACK || a == OFS_PROT) && ((p & m_lvl) != m_lvl);
        m_u.xfer(wr, a, d, p, $random(seed) & 1, rd, err);
        chk("pslverr", {31'h0, err}, {31'h0, eerr});
        if (!wr)
            chk("prdata", rd, eerr ? 32'h0 : exp_rd(a));
        if (!eerr && wr && a == OFS_RESTART && d[7:0] == RESTART_KEY)
            {e_rst, m_intr, m_warn} = {e_rst + 1, 64'h0};
        if (!eerr && wr && a == OFS_PROT)
            m_lvl = d[2:0];
        if (!eerr && !wr && a == OFS_INT_ACK)
            {e_clr, m_intr} = {e_clr + 1, 32'h0};
        settle;
    endtask
    task automatic tmo;
        @(posedge i_clk) i_timeout <= 1'b1;
        @(posedge i_clk) i_timeout <= 1'b0;
        if (m_en != 0 && !i_pause)
        begin
            if (!i_response_select || m_warn != 0)
                e_sys++;
            else
                {m_intr, m_warn} = {32'h1, 32'h1};
        end
        settle;
    endtask
    task automatic do_reset;
        @(posedge i_clk) i_rst_b <= 1'b0;
        repeat (3) @(posedge i_clk);
        i_rst_b <= 1'b1;
        {m_intr, m_warn, m_en, m_lvl} = '0;
    endtask
    task automatic print_verdict;
        $display("comparisons %0d mismatches %0d", n_tests, miscompares);
        if (miscompares == 0 && n_tests > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask

    // ==========================================================
    // scenarios
    initial
    begin
        logic [31:0] d;
        do_reset;
        settle;
        foreach (tbl[i]) op(1'b0, tbl[i], 32'h0, 3'h0);
        foreach (tbl[i]) op(1'b1, tbl[i], $random(seed), 3'h0);
        foreach (tbl[i]) op(1'b0, tbl[i], 32'h0, 3'h7);
        op(1'b1, OFS_PROT, 32'h0, 3'h7);
        tmo;
        $display("test registers done");
        @(posedge i_clk) i_enable_set <= 1'b1;
        @(posedge i_clk) i_enable_set <= 1'b0;
        m_en = 1;
        tmo;
        op(1'b0, OFS_STATUS, 32'h0, 3'h0);
        op(1'b0, OFS_INT_ACK, 32'h0, 3'h0);
        tmo;
        op(1'b1, OFS_RESTART, 32'h76, 3'h0);
        repeat (8)
        begin
            tmo;
            d = $random(seed);
            op(1'b1, OFS_RESTART, {d[31:8], d[7:0] ^ {7'h0, d[7:0] == RESTART_KEY}}, 3'h0);
            op(1'b1, OFS_RESTART, {d[31:8], RESTART_KEY}, 3'h0);
        end
        $display("test restart done");
        for (int l = 1; l < 8; l++)
        begin
            d = $random(seed);
            op(1'b1, OFS_PROT, {d[31:3], 3'(l)}, 3'h7);
            tmo;
            op(1'b1, OFS_RESTART, 32'h76, d[2:0]);
            op(1'b0, OFS_INT_ACK, 32'h0, d[5:3]);
            op(1'b0, OFS_PROT, 32'h0, 3'(l));
        end
        op(1'b1, OFS_PROT, 32'h0, 3'h7);
        op(1'b1, OFS_RESTART, 32'h76, 3'h7);
        $display("test protection done");
        @(posedge i_clk) i_pause <= 1'b1;
        settle;
        chk("freeze", {31'h0, o_counter_freeze}, 32'h1);
        tmo;
        @(posedge i_clk) i_pause <= 1'b0;
        @(posedge i_clk) i_response_select <= 1'b0;
        tmo;
        tmo;
        $display("test pause and mode done");
        do_reset;
        settle;
        tmo;
        op(1'b0, OFS_STATUS, 32'h0, 3'h0);
        $display("test second reset done");
        print_verdict;
    end
    initial
    begin
        repeat (20000) @(posedge i_clk);
        miscompares++;
        print_verdict;
    end
endmodule

bind wrsp_regs wrsp_regs_properties #(.COUNTER_WIDTH(COUNTER_WIDTH)) chk_u (.*);

`default_nettype wire
